/* File: sim/csp_host_model.sv */
// host master of the serial link: sends framed requests, samples answers
// assumes div equals the port's bit period in clk cycles
`default_nettype none
module csp_host_model
  import csp_pkg::*;
(
  input  wire logic clk,
  input  wire logic txd,
  input  wire logic tx_oe_n,
  output var  logic rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  int div = 16;
  initial rxd = 1'b1;
  // 7 data bits lsb first, even parity, one stop
  task automatic send(string s, bit bad = 1'b0);
    logic [6:0] c;
    logic [9:0] f;
    for (int i = 0; i < s.len(); i++) begin
      c = 7'(s[i]);
      f = {1'b1, (^c) ^ bad, c, 1'b0};
      for (int b = 0; b < 10; b++) begin
        rxd <= f[b];
        repeat (div) @(posedge clk);
      end
    end
  endtask
  task automatic frame(string body, bit bad = 1'b0, bit lf = 1'b1);
    wait (tx_oe_n === 1'b1);
    repeat (20) @(posedge clk); // scaled request spacing
    send(":");
    send(body, bad);
    send(lf ? "\015\012" : "\015");
  endtask
  task automatic recv(output logic [9:0] f);
    int n = 0;
    while (txd !== 1'b0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    repeat (div / 2) @(posedge clk);
    for (int b = 0; b < 10; b++) begin
      f[b] = txd;
      if (b < 9) repeat (div) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

/* File: sim/csp_port_bench.sv */
// self-checking bench of csp_port: register tasks plus a host on the link
// assumes shortened bit periods of 16 and 32 cycles
`default_nettype none
module csp_port_bench
  import csp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, nvm_busy = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic        rxd, txd, tx_oe_n, line_rs232_sel, term_on, nvm_wr;
  logic [15:0] nvm_wdata, nvm_q = 16'h0123;
  int mismatches = 0, check_count = 0, nvm_pulses = 0;
  string drops[4] = '{"020300000001FA", "010300000001FC", "010300000001FB", "010300000001FB"};
  always #5 clk = ~clk;
  csp_port #(.BIT_DIV_FAST(16), .BIT_DIV_SLOW(32)) dut (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .rxd, .txd, .tx_oe_n, .line_rs232_sel, .term_on, .nvm_wr, .nvm_wdata, .nvm_busy,
    .nvm_rdata(nvm_q));
  csp_host_model host (.clk, .txd, .tx_oe_n, .rxd);
  // slow store so that a held answer is visible
  always @(posedge clk) begin
    if (nvm_wr === 1'b1) begin
      nvm_pulses++;
      nvm_q <= nvm_wdata;
      nvm_busy <= 1'b1;
      repeat (200) @(posedge clk);
      nvm_busy <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    if (mismatches == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(string what, logic [3:0] a, logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check(what, reg_rdata, exp);
  endtask
  task automatic expect_tx(string s);
    logic [9:0] f;
    logic [6:0] c;
    for (int i = 0; i < s.len(); i++) begin
      c = 7'(s[i]);
      host.recv(f);
      check("txd char", 32'(f), 32'({1'b1, ^c, c, 1'b0}));
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rchk("config", REG_CONFIG, 32'h0001_0040);
    rchk("set_temp", REG_SET_TEMP, 32'h0000_0123);
    for (int i = 0; i < 4; i++) begin
      host.frame(drops[i], i == 2, i != 3);
      repeat (4) @(posedge clk);
      rchk("status drop", REG_STATUS, 32'h0);
    end
    host.send(":0103");
    host.frame("010300000001FB");
    repeat (4) @(posedge clk);
    rchk("status read", REG_STATUS, 32'h0000_0E01);
    wr(REG_INDEX, 32'h0);
    rchk("rx char", REG_RX_DATA, 32'h0000_0030);
    rchk("rx char", REG_RX_DATA, 32'h0000_0031);
    wr(REG_INDEX, 32'h0);
    wr(REG_TX_DATA, 32'h0000_0041);
    wr(REG_TX_DATA, 32'h0000_0042);
    wr(REG_TX_START, 32'h0000_0002);
    expect_tx(":AB\015\012");
    repeat (12) @(posedge clk);
    check("oe released", 32'(tx_oe_n), 32'h1);
    host.frame("0106000000EE0B");
    repeat (4) @(posedge clk);
    wr(REG_SET_TEMP, 32'h0000_00EE);
    rchk("temp refused", REG_SET_TEMP, 32'h0000_0123);
    for (int m = 0; m < 3; m++) begin
      wr(REG_CONFIG, 32'h0001_0040 | 32'(m));
      rchk("mode", REG_CONFIG, 32'h0001_0040 | 32'(m));
      rchk("status write", REG_STATUS, 32'h0000_0E03 | (m == 2 ? 32'h4 : 32'h0));
    end
    wr(REG_SET_TEMP, 32'h0000_00EE);
    wr(REG_SET_TEMP, 32'h0000_00EE);
    rchk("temp", REG_SET_TEMP, 32'h0000_00EE);
    rchk("status store", REG_STATUS, 32'h0000_0E17);
    check("store count", 32'(nvm_pulses), 32'h1);
    wr(REG_TX_START, 32'h0);
    @(negedge tx_oe_n);
    check("answer after store", 32'(nvm_busy), 32'h0);
    expect_tx(":\015\012");
    wr(REG_CONFIG, 32'h0064_0070);
    rchk("addr range", REG_CONFIG, 32'h0001_0070);
    check("rs232", 32'(line_rs232_sel), 32'h1);
    check("term", 32'(term_on), 32'h1);
    wr(REG_CONFIG, 32'h0000_0004);
    rchk("simple one", REG_CONFIG, 32'h0000_0004);
    wr(REG_CONFIG, 32'h0000_0088);
    rchk("blanked", REG_CONFIG, 32'h0000_0088);
    wr(REG_CONFIG, 32'h0000_008A);
    rchk("serial refused", REG_CONFIG, 32'h0000_0088);
    wr(REG_CONFIG, 32'h0002_0000);
    host.div = 32;
    host.frame("020300000001FA");
    repeat (4) @(posedge clk);
    rchk("slow station 2", REG_STATUS, 32'h0000_0E01);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rchk("temp kept", REG_SET_TEMP, 32'h0000_00EE);
    print_verdict();
  end
endmodule
`default_nettype wire

/* File: sim/csp_port_properties.sv */
// pin-level checks of the chiller serial slave port
// assumes one clock domain; bound onto every csp_port instance
`default_nettype none
module csp_port_properties
  import csp_pkg::*;
(
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic [3:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        txd,
  input wire logic        tx_oe_n,
  input wire logic        line_rs232_sel,
  input wire logic        term_on,
  input wire logic        nvm_wr,
  input wire logic [15:0] nvm_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  wire logic cfg_wr = reg_wr && reg_addr == REG_CONFIG;
  wire logic tmp_wr = reg_wr && reg_addr == REG_SET_TEMP;
  ////////////////////////////////////////////////////////////////////////////////
  chk_rdata_slot:
    assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data outside its slot");
  chk_std_follow:
    assert property (cfg_wr |=> line_rs232_sel == $past(reg_wdata[CFG_STD_BIT])) else $error("standard select wrong");
  chk_std_hold:
    assert property ($changed(line_rs232_sel) |-> $past(cfg_wr)) else $error("standard changed unasked");
  chk_term_follow:
    assert property (cfg_wr |=> term_on == $past(reg_wdata[CFG_TERM_BIT])) else $error("termination wrong");
  chk_nvm_pulse:
    assert property (nvm_wr |=> !nvm_wr) else $error("store request longer than one cycle");
  // the store may lag the register write by one stage, so both depths are allowed
  chk_nvm_cause:
    assert property (nvm_wr |-> ($past(tmp_wr) && nvm_wdata == $past(reg_wdata[15:0]))
      || ($past(tmp_wr, 2) && nvm_wdata == $past(reg_wdata[15:0], 2))) else $error("store without a write");
  chk_nvm_hold:
    assert property (!nvm_wr |-> $stable(nvm_wdata)) else $error("store data moved");
  chk_line_release:
    assert property (tx_oe_n |-> txd) else $error("line active while released");
  chk_no_initiate:
    assert property ($fell(txd) |-> !tx_oe_n) else $error("start bit without driver");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind csp_port csp_port_properties chk (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .txd,
  .tx_oe_n, .line_rs232_sel, .term_on, .nvm_wr, .nvm_wdata);
`default_nettype wire

/* File: src/csp_pkg.sv */
// constants, register map and field layout of the chiller serial slave port
// assumes a single 100 MHz clock and a firmware master on the plain register port
//
// Operation
// - half duplex; receive ignored while answering
// - 7 data bits, LSB first, even parity, 1 stop
// - speed 9600 or 19200, default 19200
// - station address 1 to 99, default 1
// - other station address gets no response
// - reads always; writes only in serial control mode
// - write acknowledged only after action completes
// - set temperature kept in nonvolatile memory
// - nonvolatile copy rewritten only on change
// - mode local, contact or serial; default local
// - protocol register or simple; default register
// - line standard RS-485 or RS-232C; default RS-485
// - 120 ohm termination switchable, default off
// - address and speed blanked outside register protocol
// - serial mode refused with protocol two conflicts
// - responder only, never initiates a transmission
// - colon discards buffered characters, starts new message
// - answer only colon-framed, CR LF terminated requests
`default_nettype none
package csp_pkg;
  localparam int CLK_HZ     = 100_000_000;
  localparam int BAUD_FAST  = 19200;
  localparam int BAUD_SLOW  = 9600;
  localparam int DIV_FAST   = CLK_HZ / BAUD_FAST;
  localparam int DIV_SLOW   = CLK_HZ / BAUD_SLOW;
  localparam int FRAME_BITS = 10;

  localparam logic [3:0] REG_CONFIG   = 4'h0;
  localparam logic [3:0] REG_STATUS   = 4'h1;
  localparam logic [3:0] REG_RX_DATA  = 4'h2;
  localparam logic [3:0] REG_INDEX    = 4'h3;
  localparam logic [3:0] REG_TX_DATA  = 4'h4;
  localparam logic [3:0] REG_TX_START = 4'h5;
  localparam logic [3:0] REG_SET_TEMP = 4'h6;

  localparam int CFG_MODE_LSB   = 0;
  localparam int CFG_PROTO_LSB  = 2;
  localparam int CFG_STD_BIT    = 4;
  localparam int CFG_TERM_BIT   = 5;
  localparam int CFG_FAST_BIT   = 6;
  localparam int CFG_EXTSW_BIT  = 7;
  localparam int CFG_REMOTE_BIT = 8;
  localparam int CFG_ADDR_LSB   = 16;

  localparam int ST_READY_BIT  = 0;
  localparam int ST_WRITE_BIT  = 1;
  localparam int ST_ALLOW_BIT  = 2;
  localparam int ST_TXACT_BIT  = 3;
  localparam int ST_NVM_BIT    = 4;
  localparam int ST_LEN_LSB    = 8;

  localparam logic [1:0] LOCAL_PANEL_MODE         = 2'h0;
  localparam logic [1:0] CONTACT_IO_MODE          = 2'h1;
  localparam logic [1:0] SERIAL_CONTROL_MODE      = 2'h2;
  localparam logic [1:0] REGISTER_PROTOCOL_CHOICE = 2'h0;
  localparam logic [1:0] SIMPLE_PROTOCOL_ONE      = 2'h1;
  localparam logic [1:0] SIMPLE_PROTOCOL_TWO      = 2'h2;

  localparam logic [1:0]  MODE_RST  = LOCAL_PANEL_MODE;
  localparam logic [1:0]  PROTO_RST = REGISTER_PROTOCOL_CHOICE;
  localparam logic        STD_RST   = 1'b0;
  localparam logic        TERM_RST  = 1'b0;
  localparam logic        FAST_RST  = 1'b1;
  localparam logic [6:0]  ADDR_RST  = 7'h01;
  localparam logic [6:0]  ADDR_MIN  = 7'h01;
  localparam logic [6:0]  ADDR_MAX  = 7'h63;
  localparam logic [15:0] TEMP_RST  = 16'h0000;

  localparam logic [6:0] CH_COLON = 7'h3A;
  localparam logic [6:0] CH_CR    = 7'h0D;
  localparam logic [6:0] CH_LF    = 7'h0A;
  localparam logic [6:0] CH_0     = 7'h30;
  localparam logic [6:0] CH_9     = 7'h39;
  localparam logic [6:0] CH_A     = 7'h41;
  localparam logic [6:0] CH_F     = 7'h46;

  localparam logic [7:0] FUNC_WR_ONE   = 8'h06;
  localparam logic [7:0] FUNC_WR_MANY  = 8'h10;
  localparam int         MIN_MSG_CHARS = 6;
endpackage
`default_nettype wire

/* File: src/csp_port.sv */
// serial slave port: request framing, station match, response sender, settings
// assumes firmware on the register port interprets requests and builds answers
//
// Local design decisions: the address map and the plain strobed port.
`default_nettype none
module csp_port
  import csp_pkg::*;
#(
  parameter int BIT_DIV_FAST = DIV_FAST,
  parameter int BIT_DIV_SLOW = DIV_SLOW,
  parameter int BUF_DEPTH    = 64,
  parameter int DIV_W        = 16
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [31:0] reg_rdata,
  input  wire logic        rxd,
  output var  logic        txd,
  output var  logic        tx_oe_n,
  output var  logic        line_rs232_sel,
  output var  logic        term_on,
  output var  logic        nvm_wr,
  output var  logic [15:0] nvm_wdata,
  input  wire logic        nvm_busy,
  input  wire logic [15:0] nvm_rdata
);
  localparam int AW = $clog2(BUF_DEPTH);

  if (BUF_DEPTH < 8 || BUF_DEPTH > 256 || BIT_DIV_SLOW >= (1 << DIV_W) || BIT_DIV_FAST < 4) begin : g_chk
    $error("csp_port: parameter out of range");
  end

  typedef enum {RX_HUNT, RX_BODY, RX_WAIT_LF} csp_rx_t;
  typedef enum {TX_IDLE, TX_HOLD, TX_COLON, TX_BODY, TX_CR, TX_LF, TX_DRAIN} csp_tx_t;

  logic [6:0]       rx_buf [BUF_DEPTH];
  logic [6:0]       tx_buf [BUF_DEPTH];
  logic             rxd_meta_reg;
  logic             rxd_sync_reg;
  logic [1:0]       mode_reg;
  logic [1:0]       proto_reg;
  logic             std_reg;
  logic             fast_reg;
  logic             extsw_reg;
  logic             remote_reg;
  logic [6:0]       addr_reg;
  csp_rx_t          rx_state_reg;
  logic [AW:0]      rx_len_reg;
  logic [3:0]       hi_nib_reg;
  logic             half_reg;
  logic             bad_reg;
  logic [7:0]       lrc_reg;
  logic             ready_reg;
  logic             is_write_reg;
  logic [AW:0]      msg_len_reg;
  logic [AW-1:0]    index_reg;
  csp_tx_t          tx_state_reg;
  logic [AW:0]      resp_len_reg;
  logic [AW:0]      tx_pos_reg;
  logic             tx_go_reg;
  logic [6:0]       tx_char_reg;
  logic [15:0]      temp_reg;
  logic             nvm_pend_reg;
  logic             boot_reg;
  logic [DIV_W-1:0] bit_div;
  logic             u_valid;
  logic             u_err;
  logic [6:0]       u_data;
  logic             u_busy;
  logic             rx_en;
  logic [4:0]       hx;
  logic [4:0]       f_hi;
  logic [4:0]       f_lo;
  logic [7:0]       station;
  logic             digits_ok;
  logic             accept;
  logic             start_ok;
  logic             tx_free;

  function automatic logic [4:0] hex_val(input logic [6:0] c);
    if (c >= CH_0 && c <= CH_9) begin
      return {1'b1, c[3:0]};
    end else if (c >= CH_A && c <= CH_F) begin
      return {1'b1, c[3:0] + 4'h9};
    end
    return 5'h00;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // line input synchroniser
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rxd_meta_reg <= 1'b1;
      rxd_sync_reg <= 1'b1;
    end else begin
      rxd_meta_reg <= rxd;
      rxd_sync_reg <= rxd_meta_reg;
    end
  end

  assign bit_div = fast_reg ? DIV_W'(BIT_DIV_FAST) : DIV_W'(BIT_DIV_SLOW);
  // receiver deaf while an answer is pending or on the line
  assign rx_en   = (tx_state_reg == TX_IDLE);

  csp_uart #(.DIV_W(DIV_W)) u_uart (
    .clk      (clk),
    .rstn     (rstn),
    .bit_div  (bit_div),
    .rxd      (rxd_sync_reg),
    .rx_en    (rx_en),
    .rx_valid (u_valid),
    .rx_err   (u_err),
    .rx_data  (u_data),
    .tx_start (tx_go_reg),
    .tx_data  (tx_char_reg),
    .tx_busy  (u_busy),
    .txd      (txd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // request framing and acceptance
  assign hx        = hex_val(u_data);
  assign f_hi      = hex_val(rx_buf[2]);
  assign f_lo      = hex_val(rx_buf[3]);
  assign digits_ok = rx_buf[0] >= CH_0 && rx_buf[0] <= CH_9 && rx_buf[1] >= CH_0 && rx_buf[1] <= CH_9;
  assign station   = ({4'h0, rx_buf[0][3:0]} << 3) + ({4'h0, rx_buf[0][3:0]} << 1) + {4'h0, rx_buf[1][3:0]};
  assign accept    = !bad_reg && !half_reg && lrc_reg == 8'h00 && digits_ok
                     && rx_len_reg >= (AW + 1)'(MIN_MSG_CHARS)
                     && station == {1'b0, addr_reg};
  assign start_ok  = reg_wr && reg_addr == REG_TX_START && ready_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_state_reg <= RX_HUNT;
      rx_len_reg   <= '0;
      hi_nib_reg   <= 4'h0;
      half_reg     <= 1'b0;
      bad_reg      <= 1'b0;
      lrc_reg      <= 8'h00;
    end else if (u_err) begin
      bad_reg <= 1'b1;
    end else if (u_valid) begin
      if (u_data == CH_COLON) begin
        rx_state_reg <= RX_BODY;
        rx_len_reg   <= '0;
        half_reg     <= 1'b0;
        bad_reg      <= 1'b0;
        lrc_reg      <= 8'h00;
      end else begin
        unique case (rx_state_reg)
          RX_HUNT: begin
          end
          RX_BODY: begin
            if (u_data == CH_CR) begin
              rx_state_reg <= RX_WAIT_LF;
            end else if (!hx[4] || rx_len_reg == (AW + 1)'(BUF_DEPTH)) begin
              bad_reg <= 1'b1;
            end else begin
              rx_buf[rx_len_reg[AW-1:0]] <= u_data;
              rx_len_reg <= rx_len_reg + 1'b1;
              half_reg   <= !half_reg;
              hi_nib_reg <= hx[3:0];
              if (half_reg) begin
                lrc_reg <= lrc_reg + {hi_nib_reg, hx[3:0]};
              end
            end
          end
          RX_WAIT_LF: begin
            rx_state_reg <= RX_HUNT;
          end
        endcase
      end
    end
  end

  // pending request flag: a new accepted message wins over the clear by TX_START
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ready_reg    <= 1'b0;
      is_write_reg <= 1'b0;
      msg_len_reg  <= '0;
    end else if (u_valid && rx_state_reg == RX_WAIT_LF && u_data == CH_LF && accept) begin
      ready_reg    <= 1'b1;
      is_write_reg <= {f_hi[3:0], f_lo[3:0]} == FUNC_WR_ONE || {f_hi[3:0], f_lo[3:0]} == FUNC_WR_MANY;
      msg_len_reg  <= rx_len_reg;
    end else if ((u_valid && u_data == CH_COLON) || start_ok) begin
      ready_reg    <= 1'b0;
      is_write_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // response sender
  assign tx_free = !u_busy && !tx_go_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_state_reg <= TX_IDLE;
      resp_len_reg <= '0;
      tx_pos_reg   <= '0;
      tx_go_reg    <= 1'b0;
      tx_char_reg  <= 7'h00;
      tx_oe_n      <= 1'b1;
    end else begin
      tx_go_reg <= 1'b0;
      unique case (tx_state_reg)
        TX_IDLE: begin
          if (start_ok) begin
            tx_state_reg <= TX_HOLD;
            resp_len_reg <= (reg_wdata[AW:0] > (AW + 1)'(BUF_DEPTH)) ? (AW + 1)'(BUF_DEPTH) : reg_wdata[AW:0];
          end
        end
        TX_HOLD: begin
          if (!nvm_pend_reg && !nvm_wr) begin
            tx_state_reg <= TX_COLON;
            tx_oe_n      <= 1'b0;
            tx_pos_reg   <= '0;
          end
        end
        TX_COLON: begin
          if (tx_free) begin
            tx_go_reg    <= 1'b1;
            tx_char_reg  <= CH_COLON;
            tx_state_reg <= TX_BODY;
          end
        end
        TX_BODY: begin
          if (tx_pos_reg == resp_len_reg) begin
            tx_state_reg <= TX_CR;
          end else if (tx_free) begin
            tx_go_reg   <= 1'b1;
            tx_char_reg <= tx_buf[tx_pos_reg[AW-1:0]];
            tx_pos_reg  <= tx_pos_reg + 1'b1;
          end
        end
        TX_CR: begin
          if (tx_free) begin
            tx_go_reg    <= 1'b1;
            tx_char_reg  <= CH_CR;
            tx_state_reg <= TX_LF;
          end
        end
        TX_LF: begin
          if (tx_free) begin
            tx_go_reg    <= 1'b1;
            tx_char_reg  <= CH_LF;
            tx_state_reg <= TX_DRAIN;
          end
        end
        TX_DRAIN: begin
          if (tx_free) begin
            tx_state_reg <= TX_IDLE;
            tx_oe_n      <= 1'b1;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // settings
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_reg       <= MODE_RST;
      proto_reg      <= PROTO_RST;
      std_reg        <= STD_RST;
      term_on        <= TERM_RST;
      fast_reg       <= FAST_RST;
      addr_reg       <= ADDR_RST;
      extsw_reg      <= 1'b0;
      remote_reg     <= 1'b0;
      line_rs232_sel <= STD_RST;
    end else if (reg_wr && reg_addr == REG_CONFIG) begin
      if (reg_wdata[CFG_PROTO_LSB +: 2] <= SIMPLE_PROTOCOL_TWO) begin
        proto_reg <= reg_wdata[CFG_PROTO_LSB +: 2];
      end
      std_reg        <= reg_wdata[CFG_STD_BIT];
      line_rs232_sel <= reg_wdata[CFG_STD_BIT];
      term_on        <= reg_wdata[CFG_TERM_BIT];
      extsw_reg      <= reg_wdata[CFG_EXTSW_BIT];
      remote_reg     <= reg_wdata[CFG_REMOTE_BIT];
      if (reg_wdata[CFG_MODE_LSB +: 2] <= SERIAL_CONTROL_MODE
          && !(reg_wdata[CFG_MODE_LSB +: 2] == SERIAL_CONTROL_MODE
               && reg_wdata[CFG_PROTO_LSB +: 2] == SIMPLE_PROTOCOL_TWO
               && (reg_wdata[CFG_EXTSW_BIT] || reg_wdata[CFG_REMOTE_BIT]))) begin
        mode_reg <= reg_wdata[CFG_MODE_LSB +: 2];
      end
      if (reg_wdata[CFG_PROTO_LSB +: 2] == REGISTER_PROTOCOL_CHOICE) begin
        fast_reg <= reg_wdata[CFG_FAST_BIT];
        if (reg_wdata[CFG_ADDR_LSB +: 7] >= ADDR_MIN && reg_wdata[CFG_ADDR_LSB +: 7] <= ADDR_MAX) begin
          addr_reg <= reg_wdata[CFG_ADDR_LSB +: 7];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // set temperature and its nonvolatile copy
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      temp_reg     <= TEMP_RST;
      boot_reg     <= 1'b0;
      nvm_wr       <= 1'b0;
      nvm_wdata    <= TEMP_RST;
      nvm_pend_reg <= 1'b0;
    end else begin
      nvm_wr <= 1'b0;
      if (!boot_reg) begin
        boot_reg <= 1'b1;
        temp_reg <= nvm_rdata;
      end else if (reg_wr && reg_addr == REG_SET_TEMP && ready_reg && is_write_reg
                   && mode_reg == SERIAL_CONTROL_MODE) begin
        if (reg_wdata[15:0] != temp_reg) begin
          temp_reg     <= reg_wdata[15:0];
          nvm_wr       <= 1'b1;
          nvm_wdata    <= reg_wdata[15:0];
          nvm_pend_reg <= 1'b1;
        end
      end else if (!nvm_wr && !nvm_busy) begin
        nvm_pend_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register port: buffer index, transmit buffer, read data
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      index_reg <= '0;
    end else if (reg_wr && reg_addr == REG_INDEX) begin
      index_reg <= reg_wdata[AW-1:0];
    end else if ((reg_wr && reg_addr == REG_TX_DATA) || (reg_rd && reg_addr == REG_RX_DATA)) begin
      index_reg <= index_reg + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reg_wr && reg_addr == REG_TX_DATA) begin
      tx_buf[index_reg] <= reg_wdata[6:0];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= 32'h0000_0000;
      if (reg_rd) begin
        unique case (reg_addr)
          REG_CONFIG: begin
            reg_rdata[CFG_MODE_LSB +: 2]  <= mode_reg;
            reg_rdata[CFG_PROTO_LSB +: 2] <= proto_reg;
            reg_rdata[CFG_STD_BIT]        <= std_reg;
            reg_rdata[CFG_TERM_BIT]       <= term_on;
            reg_rdata[CFG_EXTSW_BIT]      <= extsw_reg;
            reg_rdata[CFG_REMOTE_BIT]     <= remote_reg;
            if (proto_reg == REGISTER_PROTOCOL_CHOICE) begin
              reg_rdata[CFG_FAST_BIT]       <= fast_reg;
              reg_rdata[CFG_ADDR_LSB +: 7]  <= addr_reg;
            end
          end
          REG_STATUS: begin
            reg_rdata[ST_READY_BIT]           <= ready_reg;
            reg_rdata[ST_WRITE_BIT]           <= is_write_reg;
            reg_rdata[ST_ALLOW_BIT]           <= mode_reg == SERIAL_CONTROL_MODE;
            reg_rdata[ST_TXACT_BIT]           <= tx_state_reg != TX_IDLE;
            reg_rdata[ST_NVM_BIT]             <= nvm_pend_reg;
            reg_rdata[ST_LEN_LSB +: (AW + 1)] <= msg_len_reg;
          end
          REG_RX_DATA:  reg_rdata[6:0]      <= rx_buf[index_reg];
          REG_INDEX:    reg_rdata[AW-1:0]   <= index_reg;
          REG_SET_TEMP: reg_rdata[15:0]     <= temp_reg;
          default:      reg_rdata           <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

/* File: src/csp_uart.sv */
// character engine: one asynchronous receiver and one transmitter
// assumes rxd is already synchronised and bit_div is a bit period in clk cycles
`default_nettype none
module csp_uart
  import csp_pkg::*;
#(
  parameter int DIV_W = 16
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic [DIV_W-1:0] bit_div,
  input  wire logic             rxd,
  input  wire logic             rx_en,
  output var  logic             rx_valid,
  output var  logic             rx_err,
  output var  logic [6:0]       rx_data,
  input  wire logic             tx_start,
  input  wire logic [6:0]       tx_data,
  output var  logic             tx_busy,
  output var  logic             txd
);
  logic [DIV_W-1:0] rx_cnt_reg;
  logic [3:0]       rx_bit_reg;
  logic             rx_act_reg;
  logic [7:0]       rx_sh_reg;
  logic [DIV_W-1:0] tx_cnt_reg;
  logic [3:0]       tx_bit_reg;
  logic [9:0]       tx_sh_reg;

  ////////////////////////////////////////////////////////////////////////////
  // receiver: start bit checked at mid-bit so a short glitch is dropped
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_cnt_reg <= '0;
      rx_bit_reg <= 4'h0;
      rx_act_reg <= 1'b0;
      rx_sh_reg  <= 8'h00;
      rx_valid   <= 1'b0;
      rx_err     <= 1'b0;
      rx_data    <= 7'h00;
    end else begin
      rx_valid <= 1'b0;
      rx_err   <= 1'b0;
      if (!rx_act_reg) begin
        if (rx_en && !rxd) begin
          rx_act_reg <= 1'b1;
          rx_cnt_reg <= bit_div >> 1;
          rx_bit_reg <= 4'h0;
        end
      end else if (rx_cnt_reg != '0) begin
        rx_cnt_reg <= rx_cnt_reg - 1'b1;
      end else begin
        rx_cnt_reg <= bit_div - 1'b1;
        rx_bit_reg <= rx_bit_reg + 4'h1;
        if (rx_bit_reg == 4'h0) begin
          if (rxd) begin
            rx_act_reg <= 1'b0;
          end
        end else if (rx_bit_reg < 4'(FRAME_BITS - 1)) begin
          rx_sh_reg <= {rxd, rx_sh_reg[7:1]};
        end else begin
          rx_act_reg <= 1'b0;
          rx_data    <= rx_sh_reg[6:0];
          if (!rxd || ^rx_sh_reg) begin
            rx_err <= 1'b1;
          end else begin
            rx_valid <= 1'b1;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmitter: start, 7 data, even parity, stop, one full stop period kept
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_cnt_reg <= '0;
      tx_bit_reg <= 4'h0;
      tx_sh_reg  <= 10'h3FF;
      tx_busy    <= 1'b0;
      txd        <= 1'b1;
    end else if (!tx_busy) begin
      txd <= 1'b1;
      if (tx_start) begin
        tx_sh_reg  <= {1'b1, ^tx_data, tx_data, 1'b0};
        tx_busy    <= 1'b1;
        tx_cnt_reg <= '0;
        tx_bit_reg <= 4'h0;
      end
    end else if (tx_cnt_reg != '0) begin
      tx_cnt_reg <= tx_cnt_reg - 1'b1;
    end else begin
      txd        <= tx_sh_reg[0];
      tx_sh_reg  <= {1'b1, tx_sh_reg[9:1]};
      tx_cnt_reg <= bit_div - 1'b1;
      if (tx_bit_reg == 4'(FRAME_BITS)) begin
        tx_busy <= 1'b0;
      end else begin
        tx_bit_reg <= tx_bit_reg + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire
